/* hdl/sdwpm_consts.svh */
// Constants for the serial converter write and power mode block.
// Assumes inclusion by bare name from the package and modules.
`ifndef SDWPM_CONSTS_SVH
`define SDWPM_CONSTS_SVH

// -----------------------------------------------------------------
// Word layout
// -----------------------------------------------------------------
`define SDWPM_WORD_BITS      16
`define SDWPM_CODE_BITS      12
`define SDWPM_MODE_HI_POS    13
`define SDWPM_MODE_LO_POS    12
`define SDWPM_CODE_MSB_POS   11
`define SDWPM_CODE_RESET     12'h000
`define SDWPM_MODE_RESET     2'h0

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define SDWPM_CLK_PERIOD_NS  50
`define SDWPM_WAKE_5V_NS     2500
`define SDWPM_WAKE_3V_NS     5000
`define SDWPM_WAKE_5V_CYC    (`SDWPM_WAKE_5V_NS / `SDWPM_CLK_PERIOD_NS)
`define SDWPM_WAKE_3V_CYC    (`SDWPM_WAKE_3V_NS / `SDWPM_CLK_PERIOD_NS)

`endif

/* hdl/sdwpm_pkg.sv */
// Types for the serial converter write and power mode block.
// Assumes the constants header is on the include path.
`include "sdwpm_consts.svh"
package sdwpm_pkg;

   // -----------------------------------------------------------------
   // Power modes
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      SDWPM_MODE_NORMAL = 2'b00,
      SDWPM_MODE_PD_1K  = 2'b01,
      SDWPM_MODE_PD_100K = 2'b10,
      SDWPM_MODE_PD_HIZ = 2'b11
   } sdwpm_mode_t;

   // -----------------------------------------------------------------
   // Frame state
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      SDWPM_ST_IDLE  = 2'b00,
      SDWPM_ST_SHIFT = 2'b01,
      SDWPM_ST_DONE  = 2'b10
   } sdwpm_state_t;

   // -----------------------------------------------------------------
   // Output stage controls
   // -----------------------------------------------------------------
   typedef struct packed {
      logic amp_connect;
      logic term_1k;
      logic term_100k;
      logic output_valid;
   } sdwpm_outstage_t;

endpackage

/* hdl/sdwpm_sync.sv */
// Two-flop synchroniser bank for the three host pins.
// Assumes inputs are asynchronous to clk_in.
`timescale 1ns/1ps
module sdwpm_sync #(
   parameter int WIDTH = 3
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             resetn_in,
   // Data
   input  wire logic [WIDTH-1:0] async_in,
   input  wire logic [WIDTH-1:0] reset_val_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;
   logic [WIDTH-1:0] nxt_meta;
   logic [WIDTH-1:0] nxt_sync;

   // Refused at elaboration: an empty bank makes no sense.
   if (WIDTH < 1) begin
      $error("sdwpm_sync: WIDTH must be positive.");
   end

   // The first stage feeds only the second stage.
   // Pins are stored relative to their idle level, so a cleared flop means idle.
   always_comb begin
      nxt_meta = async_in ^ reset_val_in;
      nxt_sync = meta_ff;
   end

   // Resets to zero, which the output mask turns back into the idle pin levels.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end

   // The mask restores true pin polarity; after reset each bit shows its idle level.
   assign sync_out = sync_ff ^ reset_val_in;

endmodule

/* hdl/sdwpm_top.sv */
// Serial write and power mode control for a 12-bit voltage-output converter.
// Assumes the host drives frame select, shift clock and data asynchronously
// to mclk_in, and that the shift clock is far slower than mclk_in.
//
// Overview of operation
// - A falling edge on frame select starts a new word.
// - While frame select is low, data is sampled on each shift clock fall up to the 16th into a 16-bit register; later falls are ignored.
// - On the 16th falling edge the word executes, loading the code and the power mode.
// - The two leading bits are ignored, two select the mode and the last twelve are the code.
// - Mode 00 is normal, 01 is 1 kilohm to ground, 10 is 100 kilohm, 11 is high impedance.
// - Frame select rising before the 16th edge clears the shift register and discards the word.
// - After reset the code is all zeros until the first complete word.
// - A power-down word still loads its last twelve bits as the code; the code then holds until the next complete word.
// - In power-down the amplifier is disconnected and the matching termination is chosen.
// - Leaving power-down, the output becomes valid after a wake-up interval.
// - The code is straight binary, from 0 to 4095.
`timescale 1ns/1ps
`include "sdwpm_consts.svh"
module sdwpm_top
   import sdwpm_pkg::*;
#(
   parameter int WORD_BITS = `SDWPM_WORD_BITS,
   parameter int WAKE_CYC  = `SDWPM_WAKE_5V_CYC
) (
   // Clock and reset
   input  wire logic                          mclk_in,
   input  wire logic                          resetn_in,
   // Host serial pins
   input  wire logic                          frame_sel_n_in,
   input  wire logic                          shift_clk_in,
   input  wire logic                          serial_data_in,
   // Converter controls
   output logic      [`SDWPM_CODE_BITS-1:0]   code_out,
   output sdwpm_mode_t                        power_mode_out,
   output sdwpm_outstage_t                    outstage_out,
   output logic                               word_done_out
);

   // -----------------------------------------------------------------
   // Parameter checks
   // -----------------------------------------------------------------
   // Refused at elaboration: the frame logic serves a 16-bit word only.
   if (WORD_BITS != `SDWPM_WORD_BITS) begin
      $error("sdwpm_top: WORD_BITS must be 16.");
   end
   if (WAKE_CYC < 1) begin
      $error("sdwpm_top: WAKE_CYC must be at least one.");
   end

   // -----------------------------------------------------------------
   // Pin synchronisation
   // -----------------------------------------------------------------
   logic [2:0] pins_sync;
   logic       fsel_n;
   logic       sclk;
   logic       sdata;

   sdwpm_sync #(
      .WIDTH (3)
   ) sdwpm_sync_inst (
      .clk_in       (mclk_in),
      .resetn_in    (resetn_in),
      .async_in     ({frame_sel_n_in, shift_clk_in, serial_data_in}),
      .reset_val_in (3'b100),
      .sync_out     (pins_sync)
   );

   assign fsel_n = pins_sync[2];
   assign sclk   = pins_sync[1];
   assign sdata  = pins_sync[0];

   // -----------------------------------------------------------------
   // Edge detection
   // -----------------------------------------------------------------
   logic fsel_prev_ff;
   logic sclk_prev_ff;
   logic nxt_fsel_prev;
   logic nxt_sclk_prev;
   logic fsel_fall;
   logic fsel_rise;
   logic sclk_fall;

   // Previous levels start at the idle pin levels, so reset brings no false edge;
   // a frame select held low through reset still reads as a fall once synchronised.
   always_comb begin
      nxt_fsel_prev = fsel_n;
      nxt_sclk_prev = sclk;
   end

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         fsel_prev_ff <= 1'b1;
         sclk_prev_ff <= 1'b0;
      end else begin
         fsel_prev_ff <= nxt_fsel_prev;
         sclk_prev_ff <= nxt_sclk_prev;
      end
   end

   assign fsel_fall = fsel_prev_ff & ~fsel_n;
   assign fsel_rise = ~fsel_prev_ff & fsel_n;
   assign sclk_fall = sclk_prev_ff & ~sclk;

   // -----------------------------------------------------------------
   // Frame state machine and shift register
   // -----------------------------------------------------------------
   localparam int CNT_W = $clog2(`SDWPM_WORD_BITS + 1);

   sdwpm_state_t                   state_ff;
   sdwpm_state_t                   nxt_state;
   logic [`SDWPM_WORD_BITS-1:0]    shift_ff;
   logic [`SDWPM_WORD_BITS-1:0]    nxt_shift;
   logic [CNT_W-1:0]               count_ff;
   logic [CNT_W-1:0]               nxt_count;
   logic [`SDWPM_CODE_BITS-1:0]    code_ff;
   logic [`SDWPM_CODE_BITS-1:0]    nxt_code;
   sdwpm_mode_t                    mode_ff;
   sdwpm_mode_t                    nxt_mode;
   logic                           done_ff;
   logic                           nxt_done;
   logic [`SDWPM_WORD_BITS-1:0]    word_full;

   assign word_full = {shift_ff[`SDWPM_WORD_BITS-2:0], sdata};

   always_comb begin
      nxt_state = state_ff;
      nxt_shift = shift_ff;
      nxt_count = count_ff;
      nxt_code  = code_ff;
      nxt_mode  = mode_ff;
      nxt_done  = 1'b0;
      case (state_ff)
         SDWPM_ST_IDLE: begin
            if (fsel_fall) begin
               nxt_state = SDWPM_ST_SHIFT;
               nxt_shift = '0;
               nxt_count = '0;
            end
         end
         SDWPM_ST_SHIFT: begin
            if (fsel_n) begin
               nxt_state = SDWPM_ST_IDLE;
               nxt_shift = '0;
               nxt_count = '0;
            end else if (sclk_fall) begin
               nxt_shift = word_full;
               nxt_count = count_ff + CNT_W'(1);
               if (count_ff == CNT_W'(`SDWPM_WORD_BITS - 1)) begin
                  nxt_code  = word_full[`SDWPM_CODE_MSB_POS:0];
                  nxt_mode  = sdwpm_mode_t'(word_full[`SDWPM_MODE_HI_POS:`SDWPM_MODE_LO_POS]);
                  nxt_done  = 1'b1;
                  nxt_state = SDWPM_ST_DONE;
               end
            end
         end
         SDWPM_ST_DONE: begin
            if (fsel_rise) begin
               nxt_state = SDWPM_ST_IDLE;
               nxt_count = '0;
            end
         end
         default: begin
            nxt_state = SDWPM_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_ff <= SDWPM_ST_IDLE;
         shift_ff <= '0;
         count_ff <= '0;
         code_ff  <= `SDWPM_CODE_RESET;
         mode_ff  <= sdwpm_mode_t'(`SDWPM_MODE_RESET);
         done_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         shift_ff <= nxt_shift;
         count_ff <= nxt_count;
         code_ff  <= nxt_code;
         mode_ff  <= nxt_mode;
         done_ff  <= nxt_done;
      end
   end

   // -----------------------------------------------------------------
   // Output stage and wake-up timer
   // -----------------------------------------------------------------
   localparam int WAKE_W = $clog2(WAKE_CYC + 1);

   logic [WAKE_W-1:0] wake_ff;
   logic [WAKE_W-1:0] nxt_wake;
   sdwpm_outstage_t   stage_ff;
   sdwpm_outstage_t   nxt_stage;

   // The timer restarts whenever a power-down mode is held, so leaving it
   // always costs the full interval; a typical figure, not a worst case.
   always_comb begin
      nxt_wake  = wake_ff;
      nxt_stage = '0;
      if (mode_ff != SDWPM_MODE_NORMAL) begin
         nxt_wake = WAKE_W'(WAKE_CYC);
      end else if (wake_ff != '0) begin
         nxt_wake = wake_ff - WAKE_W'(1);
      end
      case (mode_ff)
         SDWPM_MODE_NORMAL: nxt_stage.amp_connect = 1'b1;
         SDWPM_MODE_PD_1K:  nxt_stage.term_1k     = 1'b1;
         SDWPM_MODE_PD_100K: nxt_stage.term_100k  = 1'b1;
         default:           nxt_stage             = '0;
      endcase
      nxt_stage.output_valid = (mode_ff == SDWPM_MODE_NORMAL) && (nxt_wake == '0);
   end

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wake_ff  <= '0;
         stage_ff <= '0;
      end else begin
         wake_ff  <= nxt_wake;
         stage_ff <= nxt_stage;
      end
   end

   assign code_out       = code_ff;
   assign power_mode_out = mode_ff;
   assign outstage_out   = stage_ff;
   assign word_done_out  = done_ff;

endmodule

/* verification/sdwpm_host_model.sv */
// Host serial master model for frame select, shift clock and data.
// Assumes mclk_in runs at 20 MHz; pins change on its falling edge.
`timescale 1ns/1ps
module sdwpm_host_model (
   // Timing reference
   input  wire logic mclk_in,
   // Serial pins
   output logic      frame_sel_n_out,
   output logic      shift_clk_out,
   output logic      serial_data_out
);
   // Half of the 400 ns shift clock period.
   localparam int HALF = 4;

   // The shift clock stands still between frames.
   initial begin
      frame_sel_n_out = 1'b1;
      shift_clk_out = 1'b0;
      serial_data_out = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge mclk_in);
   endtask

   // Sends the top nbits of word; fresh gives the brief high first.
   task automatic send_word(input logic [15:0] word, input int nbits, input logic keep_low,
                            input logic fresh);
      tick(1);
      if (fresh) begin
         frame_sel_n_out = 1'b1;
         tick(HALF);
         frame_sel_n_out = 1'b0;
         tick(HALF);
      end
      for (int i = 0; i < nbits; i++) begin
         serial_data_out = word[15-i];
         shift_clk_out = 1'b1;
         tick(HALF);
         shift_clk_out = 1'b0;
         tick(HALF);
      end
      // Hold time is over, so the data line no longer shows the last bit.
      serial_data_out = ~serial_data_out;
      if (!keep_low) begin
         frame_sel_n_out = 1'b1;
      end
   endtask
endmodule

/* verification/sdwpm_sva.sv */
// Concurrent checks on the ports of the serial write block.
// Assumes a bind to sdwpm_top and one clock domain on mclk_in.
`timescale 1ns/1ps
module sdwpm_sva
   import sdwpm_pkg::*;
#(
   parameter int WAKE_CYC = 2
) (
   // Clock and reset
   input  wire logic            mclk_in,
   input  wire logic            resetn_in,
   // Host pins
   input  wire logic            frame_sel_n_in,
   input  wire logic            shift_clk_in,
   // Converter controls
   input  wire logic [11:0]     code_out,
   input  wire sdwpm_mode_t     power_mode_out,
   input  wire sdwpm_outstage_t outstage_out,
   input  wire logic            word_done_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);

   // -----------------------------------------------------------------
   // Sequences
   // -----------------------------------------------------------------
   // A return to normal mode opens the wake window.
   sequence wake_start;
      $changed(power_mode_out) && power_mode_out == SDWPM_MODE_NORMAL;
   endsequence
   // Valid stays low for WAKE_CYC cycles from the mode change and then rises.
   localparam int WAKE_M1 = WAKE_CYC - 1;
   sequence wake_then_valid;
      !outstage_out.output_valid ##WAKE_M1 !outstage_out.output_valid ##1 outstage_out.output_valid;
   endsequence
   // A mode held for two cycles lets the output stage settle first.
   logic pd_held;
   assign pd_held = power_mode_out != SDWPM_MODE_NORMAL;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   code_hold_a: assert property (!word_done_out |-> $stable(code_out))
      else $error("code changed without a word");
   mode_hold_a: assert property (!word_done_out |-> $stable(power_mode_out))
      else $error("mode changed without a word");
   done_single_a: assert property (word_done_out |=> !word_done_out [*6])
      else $error("word done repeated");
   done_on_fall_a: assert property (word_done_out |-> !$past(shift_clk_in, 2))
      else $error("word done without a clock fall");
   done_in_frame_a: assert property (word_done_out |-> !$past(frame_sel_n_in, 4))
      else $error("word done outside a frame");
   pd_amp_off_a: assert property (pd_held && $stable(power_mode_out) |->
      !outstage_out.amp_connect && !outstage_out.output_valid) else $error("amplifier on in power-down");
   pd_term_a: assert property (pd_held && $stable(power_mode_out) |->
      outstage_out.term_1k == (power_mode_out == SDWPM_MODE_PD_1K) &&
      outstage_out.term_100k == (power_mode_out == SDWPM_MODE_PD_100K)) else $error("wrong termination");
   wake_valid_a: assert property (wake_start |-> wake_then_valid)
      else $error("wake interval wrong");
endmodule

bind sdwpm_top sdwpm_sva #(.WAKE_CYC(WAKE_CYC)) sdwpm_sva_inst (
   .mclk_in(mclk_in), .resetn_in(resetn_in), .frame_sel_n_in(frame_sel_n_in),
   .shift_clk_in(shift_clk_in), .code_out(code_out), .power_mode_out(power_mode_out),
   .outstage_out(outstage_out), .word_done_out(word_done_out));

/* verification/sdwpm_top_tb_top.sv */
// Self-checking bench for the serial write and power mode block.
// Assumes the host model and the checker are compiled before it.
`timescale 1ns/1ps
module sdwpm_top_tb_top;
   import sdwpm_pkg::*;
   // A short wake count keeps the run brief.
   localparam int WAKE = 2;
   logic            mclk_in;
   logic            resetn_in;
   logic            fs_n, sclk, sdata, done;
   logic [11:0]     code;
   sdwpm_mode_t     mode;
   sdwpm_outstage_t stage;
   int              err_count, check_count, n_exp;
   int              done_cnt = 0;

   sdwpm_top #(.WAKE_CYC(WAKE)) sdwpm_top_inst (
      .mclk_in(mclk_in), .resetn_in(resetn_in), .frame_sel_n_in(fs_n), .shift_clk_in(sclk),
      .serial_data_in(sdata), .code_out(code), .power_mode_out(mode), .outstage_out(stage),
      .word_done_out(done));
   sdwpm_host_model sdwpm_host_model_inst (.mclk_in(mclk_in), .frame_sel_n_out(fs_n),
      .shift_clk_out(sclk), .serial_data_out(sdata));

   // 20 MHz clock.
   initial begin
      mclk_in = 1'b0;
      forever #25 mclk_in = ~mclk_in;
   end

   // Counts executed words from the one-cycle done pulse.
   always @(posedge mclk_in) begin
      if (done === 1'b1) done_cnt++;
   end

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Lets sync and wake settle, then compares every output.
   task automatic expect_out(input logic [11:0] c, input sdwpm_mode_t m);
      logic [3:0] st;
      repeat (12) @(negedge mclk_in);
      case (m)
         SDWPM_MODE_NORMAL:  st = 4'h9;
         SDWPM_MODE_PD_1K:   st = 4'h4;
         SDWPM_MODE_PD_100K: st = 4'h2;
         default:            st = 4'h0;
      endcase
      check("code", {4'h0, c}, {4'h0, code});
      check("mode", {14'h0, m}, {14'h0, mode});
      check("stage", {12'h0, st}, {12'h0, stage});
      check("done", n_exp[15:0], done_cnt[15:0]);
   endtask

   task automatic send(input logic [15:0] w, input int nb, input logic keep, input logic fresh);
      sdwpm_host_model_inst.send_word(w, nb, keep, fresh);
   endtask

   task automatic t_reset;
      expect_out(12'h000, SDWPM_MODE_NORMAL);
      $display("test reset ended");
   endtask

   task automatic t_modes;
      sdwpm_mode_t m;
      send(16'hCA5C, 16, 1'b0, 1'b1);
      n_exp++;
      expect_out(12'hA5C, SDWPM_MODE_NORMAL);
      for (int i = 1; i <= 4; i++) begin
         m = sdwpm_mode_t'(i[1:0]);
         send({2'b10, m, 12'hA5C}, 16, 1'b0, 1'b1);
         n_exp++;
         expect_out(12'hA5C, m);
      end
      $display("test modes ended");
   endtask

   task automatic t_abort;
      send(16'h3123, 10, 1'b0, 1'b1);
      expect_out(12'hA5C, SDWPM_MODE_NORMAL);
      send(16'h0FFF, 16, 1'b0, 1'b1);
      n_exp++;
      expect_out(12'hFFF, SDWPM_MODE_NORMAL);
      $display("test abort ended");
   endtask

   task automatic t_extra;
      send(16'h0000, 16, 1'b1, 1'b1);
      n_exp++;
      send(16'hFFFF, 8, 1'b1, 1'b0);
      expect_out(12'h000, SDWPM_MODE_NORMAL);
      send(16'h0801, 16, 1'b0, 1'b1);
      n_exp++;
      expect_out(12'h801, SDWPM_MODE_NORMAL);
      $display("test extra edges ended");
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // The tests take about 1400 cycles; the limit allows nearly thirty times that.
   initial begin
      #2000000;
      err_count++;
      give_verdict();
   end

   initial begin
      resetn_in = 1'b0;
      err_count = 0;
      check_count = 0;
      n_exp = 0;
      repeat (6) @(negedge mclk_in);
      resetn_in = 1'b1;
      t_reset();
      t_modes();
      t_abort();
      t_extra();
      give_verdict();
   end
endmodule
